// File: src/muxed_bus_slave_defines.svh
// constants for the multiplexed host bus slave
// assumes inclusion by bare name from the design files
// How it works
// - address latch strobe falling edge captures the low address byte from shared port while the program fetch strobe is high
// - only the shared port value captured at the latch strobe fall counts as the address; later values are data
// - no wait states; device answers within the host strobe windows
// - on read strobe the addressed device drives the register onto the port
// - low read strobe marks a read from the device
// - low write strobe marks a write into the device
// - high address byte arrives on its own dedicated input lines
// - active-low interrupt request output driven from application logic
// - active-high reset returns all logic to its initial state
// - one system clock runs the logic, independent of the bus strobes
// - host writes control registers; application posts status for host reads
// - high address byte equal to the base select gives a device match
// - matched with a strobe active: read drives register, write loads register
// - strobe negation enters end state, releases port, idle on latch negation
`ifndef MUXED_BUS_SLAVE_DEFINES_SVH
`define MUXED_BUS_SLAVE_DEFINES_SVH
`define DEVICE_BASE_SELECT 8'h00
`define REG_STATUS_OFS 8'h80
`define REG_CTRL_OFS 8'h82
`define REG_DATAIN_OFS 8'h84
`define REG_DATAOUT_OFS 8'h86
`define REG_COUNT 4
`define CTRL_RESET 8'h00
`define DATAIN_RESET 8'h00
`endif

// File: src/muxed_bus_slave_pkg.sv
// types for the multiplexed host bus slave
// assumes nothing beyond the defines header
package muxed_bus_slave_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_XFER = 4'b0100,
    ST_END = 4'b1000
  } bus_state_t;
endpackage

// File: src/strobe_sync.sv
// two-flop synchroniser for a group of host strobes
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
module strobe_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;
  if (WIDTH < 1) begin : g_width_check
    $error("strobe_sync needs at least one strobe");
  end
  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= {RESET_VAL, RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule // strobe_sync

// File: src/muxed_bus_slave.sv
// multiplexed address/data host bus slave with a small register file
// assumes host strobes asynchronous to clk and slow against its period
`include "muxed_bus_slave_defines.svh"
`timescale 1ns/100ps
module muxed_bus_slave #(
  parameter logic [7:0] BASE_SELECT = `DEVICE_BASE_SELECT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] host_high_addr,
  input wire logic [7:0] host_shared_low_port_in,
  output logic [7:0] host_shared_low_port_out,
  output logic host_shared_low_port_oe,
  input wire logic addr_latch_strobe_n,
  input wire logic program_fetch_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  output logic irq_n,
  input wire logic app_irq,
  input wire logic [7:0] app_status,
  input wire logic [7:0] app_data_out,
  output logic [7:0] app_ctrl,
  output logic [7:0] app_data_in,
  output logic app_ctrl_wr,
  output logic app_data_in_wr
);
  // ==========================================================
  // strobe synchronisation
  logic [3:0] strb_s;
  strobe_sync #(
    .WIDTH(4),
    .RESET_VAL(4'hF)
  ) strobe_sync_inst (
    .clk(clk),
    .rst(rst),
    .async_in({addr_latch_strobe_n, program_fetch_strobe_n, read_strobe_n, write_strobe_n}),
    .sync_out(strb_s)
  );
  // all strobes idle high, so reset to ones keeps a false edge away
  // after reset is released
  logic ale_s;
  logic fetch_s;
  logic rd_s;
  logic wr_s;
  assign ale_s = strb_s[3];
  assign fetch_s = strb_s[2];
  assign rd_s = strb_s[1];
  assign wr_s = strb_s[0];

  // ==========================================================
  // state
  typedef struct packed {
    muxed_bus_slave_pkg::bus_state_t st;
    logic ale_prev;
    logic [7:0] low_addr;
    logic [7:0] high_addr;
    logic is_read;
    logic [7:0] ctrl;
    logic [7:0] data_in;
    logic [7:0] dout;
    logic oe;
    logic irq_n;
    logic ctrl_wr;
    logic data_in_wr;
  } slave_state_t;
  slave_state_t s_q;
  slave_state_t s_d;
  logic match;
  logic [7:0] rd_mux;
  logic ale_fall;
  // the port is sampled three clocks after the pin moved; the host holds the
  // address well past the latch edge, so the sampled value is still the address
  assign ale_fall = s_q.ale_prev && !ale_s;
  assign match = (s_q.high_addr == BASE_SELECT);

  always_comb begin
    unique case (s_q.low_addr)
      `REG_STATUS_OFS: rd_mux = app_status;
      `REG_CTRL_OFS: rd_mux = s_q.ctrl;
      `REG_DATAIN_OFS: rd_mux = s_q.data_in;
      `REG_DATAOUT_OFS: rd_mux = app_data_out;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ale_prev = ale_s;
    s_d.irq_n = !app_irq;
    s_d.ctrl_wr = 1'b0;
    s_d.data_in_wr = 1'b0;
    unique case (s_q.st)
      muxed_bus_slave_pkg::ST_IDLE: begin
        if (ale_fall && fetch_s) begin
          s_d.low_addr = host_shared_low_port_in;
          s_d.high_addr = host_high_addr;
          s_d.st = muxed_bus_slave_pkg::ST_DECODE;
        end
      end
      muxed_bus_slave_pkg::ST_DECODE: begin
        // latch strobe rising before any strobe ends the cycle unanswered
        if (ale_s || !fetch_s) begin
          s_d.st = muxed_bus_slave_pkg::ST_IDLE;
        end else if (match && !rd_s) begin
          s_d.is_read = 1'b1;
          s_d.dout = rd_mux;
          s_d.oe = 1'b1;
          s_d.st = muxed_bus_slave_pkg::ST_XFER;
        end else if (match && !wr_s) begin
          s_d.is_read = 1'b0;
          s_d.st = muxed_bus_slave_pkg::ST_XFER;
        end
      end
      muxed_bus_slave_pkg::ST_XFER: begin
        if (s_q.is_read) begin
          // no wait states: keep driving fresh data until the host ends
          s_d.dout = rd_mux;
          if (rd_s) begin
            s_d.oe = 1'b0;
            s_d.st = muxed_bus_slave_pkg::ST_END;
          end
        end else if (wr_s) begin
          // data is still held on the port after the write strobe rises
          if (s_q.low_addr == `REG_CTRL_OFS) begin
            s_d.ctrl = host_shared_low_port_in;
            s_d.ctrl_wr = 1'b1;
          end
          if (s_q.low_addr == `REG_DATAIN_OFS) begin
            s_d.data_in = host_shared_low_port_in;
            s_d.data_in_wr = 1'b1;
          end
          s_d.st = muxed_bus_slave_pkg::ST_END;
        end
      end
      muxed_bus_slave_pkg::ST_END: begin
        s_d.oe = 1'b0;
        if (ale_s) begin
          s_d.st = muxed_bus_slave_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = muxed_bus_slave_pkg::ST_IDLE;
        s_d.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.st <= muxed_bus_slave_pkg::ST_IDLE;
      s_q.ale_prev <= 1'b1;
      s_q.low_addr <= 8'h00;
      s_q.high_addr <= 8'h00;
      s_q.is_read <= 1'b0;
      s_q.ctrl <= `CTRL_RESET;
      s_q.data_in <= `DATAIN_RESET;
      s_q.dout <= 8'h00;
      s_q.oe <= 1'b0;
      s_q.irq_n <= 1'b1;
      s_q.ctrl_wr <= 1'b0;
      s_q.data_in_wr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign host_shared_low_port_out = s_q.dout;
  assign host_shared_low_port_oe = s_q.oe;
  assign irq_n = s_q.irq_n;
  assign app_ctrl = s_q.ctrl;
  assign app_data_in = s_q.data_in;
  assign app_ctrl_wr = s_q.ctrl_wr;
  assign app_data_in_wr = s_q.data_in_wr;

  // ==========================================================
  // checks
  // every check is clocked by clk and silenced while rst is high

  // ==========================================================
  // state encoding checks

  state_onehot_a: assert property (@(posedge clk) disable iff (rst)
    $onehot(s_q.st))
    else $error("bus state not one-hot");

  // ==========================================================
  // address capture checks

  latch_addr_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_IDLE && ale_fall && fetch_s)
    |=> (s_q.low_addr == $past(host_shared_low_port_in)))
    else $error("low address not latched on latch strobe fall");

  high_latch_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_IDLE && ale_fall && fetch_s)
    |=> (s_q.high_addr == $past(host_high_addr)))
    else $error("high address not latched on latch strobe fall");

  decode_entry_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_IDLE && ale_fall && fetch_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_DECODE)
    else $error("no decode after latch strobe fall");

  fetch_ignored_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_IDLE && !fetch_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_IDLE)
    else $error("program fetch cycle answered");

  fetch_abort_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && !fetch_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_IDLE)
    else $error("fetch strobe did not abort decode");

  decode_abort_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && ale_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_IDLE)
    else $error("latch strobe rise did not abort decode");

  nomatch_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && !match) |=> !s_q.oe)
    else $error("unmatched cycle answered");

  write_nomatch_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && !match)
    |=> s_q.st != muxed_bus_slave_pkg::ST_XFER)
    else $error("unmatched cycle entered a transfer");

  // ==========================================================
  // read path checks

  oe_only_read_a: assert property (@(posedge clk) disable iff (rst)
    s_q.oe |-> (s_q.is_read && s_q.st == muxed_bus_slave_pkg::ST_XFER))
    else $error("port driven outside a read transfer");

  read_drive_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && ale_s == 1'b0 && fetch_s && match && !rd_s)
    |=> s_q.oe ##0 s_q.dout == $past(rd_mux))
    else $error("read data not driven");

  read_hold_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_XFER && s_q.is_read && !rd_s)
    |=> s_q.oe)
    else $error("port dropped while read strobe low");

  dout_refresh_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_XFER && s_q.is_read && !rd_s)
    |=> s_q.dout == $past(rd_mux))
    else $error("read data not refreshed");

  end_release_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_XFER && s_q.is_read && rd_s)
    |=> !s_q.oe && s_q.st == muxed_bus_slave_pkg::ST_END)
    else $error("port not released at read end");

  end_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_END) |=> !s_q.oe)
    else $error("port driven in end state");

  idle_return_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_END && ale_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_IDLE)
    else $error("no return to idle");

  // ==========================================================
  // write path checks

  write_enter_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_DECODE && !ale_s && fetch_s && match && rd_s && !wr_s)
    |=> s_q.st == muxed_bus_slave_pkg::ST_XFER && !s_q.is_read)
    else $error("write strobe not taken");

  write_load_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_XFER && !s_q.is_read && wr_s
     && s_q.low_addr == `REG_CTRL_OFS)
    |=> app_ctrl == $past(host_shared_low_port_in) && app_ctrl_wr)
    else $error("control write lost");

  data_in_load_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == muxed_bus_slave_pkg::ST_XFER && !s_q.is_read && wr_s
     && s_q.low_addr == `REG_DATAIN_OFS)
    |=> app_data_in == $past(host_shared_low_port_in) && app_data_in_wr)
    else $error("data input write lost");

  // the control register may only move on a completed host write
  ctrl_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(s_q.st == muxed_bus_slave_pkg::ST_XFER && !s_q.is_read && wr_s
      && s_q.low_addr == `REG_CTRL_OFS)
    |=> $stable(s_q.ctrl))
    else $error("control register changed without a write");

  ctrl_pulse_once_a: assert property (@(posedge clk) disable iff (rst)
    app_ctrl_wr |=> !app_ctrl_wr)
    else $error("control write pulse too long");

  din_pulse_once_a: assert property (@(posedge clk) disable iff (rst)
    app_data_in_wr |=> !app_data_in_wr)
    else $error("data input write pulse too long");

  // ==========================================================
  // interrupt checks

  irq_follow_a: assert property (@(posedge clk) disable iff (rst)
    app_irq |=> !irq_n)
    else $error("interrupt request not raised");

  irq_clear_a: assert property (@(posedge clk) disable iff (rst)
    !app_irq |=> irq_n)
    else $error("interrupt request not cleared");

endmodule // muxed_bus_slave

// File: testbench/host_bus_model.sv
// host bus master model: drives latch, strobes, high byte and shared port
// assumes the bench calls bus_cycle and supplies clk
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] port_out,
  input wire logic port_oe,
  output logic [7:0] high_addr,
  output logic [7:0] port_in,
  output logic ale_n,
  output logic fetch_n,
  output logic rd_n,
  output logic wr_n,
  output logic oe_seen
);
  logic [7:0] host_val = 8'h00;
  logic host_drv = 1'b0;
  initial begin
    high_addr = 8'hFF;
    ale_n = 1'b1;
    fetch_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    oe_seen = 1'b0;
  end
  // released port shows the inverse of the last host value
  assign port_in = port_oe ? port_out : (host_drv ? host_val : ~host_val);
  always @(posedge clk) if (port_oe) oe_seen <= 1'b1;
  task automatic bus_cycle(input logic [7:0] hi, input logic [7:0] lo, input logic wr,
                           input logic [7:0] wd, input logic fetch, output logic [7:0] rd);
    @(posedge clk);
    oe_seen <= 1'b0;
    high_addr <= hi;
    host_val <= lo;
    host_drv <= 1'b1;
    fetch_n <= ~fetch;
    repeat (2) @(posedge clk);
    ale_n <= 1'b0;
    repeat (5) @(posedge clk);
    host_val <= wd;
    host_drv <= wr;
    @(posedge clk);
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd = port_in;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    host_drv <= 1'b0;
    ale_n <= 1'b1;
    repeat (4) @(posedge clk);
    fetch_n <= 1'b1;
    high_addr <= ~hi;
  endtask
endmodule // host_bus_model

// File: testbench/muxed_bus_slave_interface_tb.sv
// bench for the multiplexed host bus slave
// assumes host_bus_model as the bus master
`timescale 1ns/100ps
module mcu_muxed_bus_slave_interface_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic app_irq = 1'b0;
  logic [7:0] app_status = 8'h00;
  logic [7:0] app_data_out = 8'h00;
  logic [7:0] hi, pin, pout, ctrl, din, d;
  logic oe, ale_n, fetch_n, rd_n, wr_n, irq_n, ctrl_wr, din_wr, oe_seen;
  int error_cnt = 0;
  int comparisons = 0;
  int ctrl_pulses = 0;
  int din_pulses = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    ctrl_pulses += (ctrl_wr === 1'b1);
    din_pulses += (din_wr === 1'b1);
  end
  muxed_bus_slave muxed_bus_slave_inst (.clk(clk), .rst(rst), .host_high_addr(hi),
    .host_shared_low_port_in(pin), .host_shared_low_port_out(pout),
    .host_shared_low_port_oe(oe), .addr_latch_strobe_n(ale_n),
    .program_fetch_strobe_n(fetch_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .irq_n(irq_n), .app_irq(app_irq), .app_status(app_status),
    .app_data_out(app_data_out), .app_ctrl(ctrl), .app_data_in(din),
    .app_ctrl_wr(ctrl_wr), .app_data_in_wr(din_wr));
  host_bus_model host_bus_model_inst (.clk(clk), .port_out(pout), .port_oe(oe),
    .high_addr(hi), .port_in(pin), .ale_n(ale_n), .fetch_n(fetch_n), .rd_n(rd_n),
    .wr_n(wr_n), .oe_seen(oe_seen));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input logic [7:0] h, input logic [7:0] l, input logic w,
                     input logic [7:0] wd, input logic f);
    host_bus_model_inst.bus_cycle(h, l, w, wd, f, d);
  endtask
  task automatic t_reset;
    chk({5'h00, oe, irq_n, din_wr}, 8'h02, "reset outputs");
    chk(ctrl, 8'h00, "ctrl reset");
    chk(din, 8'h00, "data_in reset");
    $display("test reset done");
  endtask
  task automatic t_write_read;
    cyc(8'h00, 8'h82, 1'b1, 8'hA5, 1'b0);
    chk(ctrl, 8'hA5, "ctrl write");
    chk(8'(ctrl_pulses), 8'h01, "ctrl pulse");
    cyc(8'h00, 8'h84, 1'b1, 8'h3C, 1'b0);
    chk(din, 8'h3C, "data_in write");
    chk(8'(din_pulses), 8'h01, "data_in pulse");
    cyc(8'h00, 8'h82, 1'b0, 8'h00, 1'b0);
    chk(d, 8'hA5, "ctrl readback");
    cyc(8'h00, 8'h84, 1'b0, 8'h00, 1'b0);
    chk(d, 8'h3C, "data_in readback");
    $display("test write_read done");
  endtask
  task automatic t_app_read;
    app_status <= 8'h5A;
    app_data_out <= 8'hC3;
    cyc(8'h00, 8'h80, 1'b0, 8'h00, 1'b0);
    chk(d, 8'h5A, "status read");
    cyc(8'h00, 8'h86, 1'b0, 8'h00, 1'b0);
    chk(d, 8'hC3, "data_out read");
    cyc(8'h00, 8'h88, 1'b0, 8'h00, 1'b0);
    chk(d, 8'h00, "unmapped read");
    chk({7'h00, oe_seen}, 8'h01, "port driven on read");
    chk({7'h00, oe}, 8'h00, "port released");
    $display("test app_read done");
  endtask
  task automatic t_refused;
    cyc(8'h00, 8'h80, 1'b1, 8'h11, 1'b0);
    cyc(8'h01, 8'h82, 1'b1, 8'h22, 1'b0);
    chk(ctrl, 8'hA5, "foreign write");
    cyc(8'h01, 8'h82, 1'b0, 8'h00, 1'b0);
    chk({7'h00, oe_seen}, 8'h00, "foreign read");
    cyc(8'h00, 8'h82, 1'b1, 8'hFF, 1'b1);
    chk(ctrl, 8'hA5, "fetch write");
    cyc(8'h00, 8'h82, 1'b0, 8'h00, 1'b1);
    chk({7'h00, oe_seen}, 8'h00, "fetch read");
    cyc(8'h00, 8'h86, 1'b1, 8'h77, 1'b0);
    chk(ctrl, 8'hA5, "read-only write");
    chk(8'(ctrl_pulses), 8'h01, "no stray pulse");
    chk(8'(din_pulses), 8'h01, "no stray data_in pulse");
    $display("test refused done");
  endtask
  task automatic t_irq;
    app_irq <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, irq_n}, 8'h00, "irq asserted");
    app_irq <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, irq_n}, 8'h01, "irq cleared");
    $display("test irq done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_write_read();
    t_app_read();
    t_refused();
    t_irq();
    close_out();
  end
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule // mcu_muxed_bus_slave_interface_tb
